// ===== angular_positioning_sequencer_tb.sv
// self-checking bench for the positioning sequencer
// assumes aps_seq with short settle and blink counts, motor fb = ref
`timescale 1ns/1ps
module angular_positioning_sequencer_tb;
   import aps_pkg::*;
   localparam int unsigned SC = 20;
   localparam int unsigned BC = 8;
   logic          clk, rst_n, psel, penable, pwrite, cmd_in;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata_q, rd_q;
   logic          pready_q, pslverr_q, er_q, enc_a, enc_b, enc_zero;
   aps_speed_type speed_fb, speed_demand, speed_ref_q;
   logic          pos_loop_active_q, suppress_q, display_h_q;
   logic          display_3_q, irq_q;
   logic [15:0]   speed_kp_q, speed_ki_q, speed_kd_q;
   logic [5:0]    logic_outputs_q;
   int            err_total, n_compared, i;
   // reverse ref 3 = 8 pulses per turn - forward 5
   // hold gains differ: gain change wanted
   // row: write, address, data or expected read, expected error
   logic [45:0]   rows [20] = '{
      {1'b0,12'h000,32'h0,1'b0}, {1'b0,12'h004,32'h0,1'b0},
      {1'b0,12'h034,32'h2710,1'b0}, {1'b0,12'h018,32'h100,1'b0},
      {1'b0,12'h0FC,32'h0,1'b1}, {1'b1,12'h03C,32'h5,1'b1},
      {1'b0,12'h03C,32'h0,1'b0}, {1'b1,12'h004,32'h2,1'b0},
      {1'b1,12'h008,32'hA,1'b0}, {1'b1,12'h00C,32'h5,1'b0},
      {1'b1,12'h010,32'h3,1'b0}, {1'b1,12'h014,32'h3,1'b0},
      {1'b1,12'h01C,32'h21,1'b0}, {1'b1,12'h020,32'h22,1'b0},
      {1'b1,12'h024,32'h23,1'b0}, {1'b1,12'h028,32'h11,1'b0},
      {1'b1,12'h02C,32'h12,1'b0}, {1'b1,12'h030,32'h13,1'b0},
      {1'b1,12'h038,32'h3E01,1'b0}, {1'b1,12'h044,32'h1,1'b0}};
   aps_seq #(.SETTLE_CYC(SC), .BLINK_CYC(BC)) aps_seq_i (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .position_command_input(cmd_in), .enc_a(enc_a), .enc_b(enc_b),
      .enc_zero(enc_zero), .speed_fb(speed_fb),
      .speed_demand(speed_demand), .speed_ref_q(speed_ref_q),
      .pos_loop_active_q(pos_loop_active_q), .suppress_q(suppress_q),
      .display_h_q(display_h_q), .display_3_q(display_3_q),
      .speed_kp_q(speed_kp_q), .speed_ki_q(speed_ki_q),
      .speed_kd_q(speed_kd_q), .logic_outputs_q(logic_outputs_q),
      .irq_q(irq_q));
   aps_enc_model aps_enc_model_i (
      .clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_zero(enc_zero));
   always #4 clk = ~clk;
   // motor follows its reference one cycle late
   always @(posedge clk) speed_fb <= speed_ref_q;
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("Error at %0t: saw %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         $display("Error at %0t: wait ran out", $time);
         err_total++;
         conclude();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready_q === 1'b1) break;
      end
      tmo(n, 20);
      rd_q = prdata_q;
      er_q = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic st(input logic [2:0] e);
      apb(1'b0, 12'h03C, 32'h0);
      chk(rd_q[2:0], e);
   endtask
   initial begin
      clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; cmd_in = 0; speed_fb = 0;
      speed_demand = 16'sd50; err_total = 0; n_compared = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[k]) begin
         apb(rows[k][45], rows[k][44:33], rows[k][32:1]);
         if (!rows[k][45]) chk(rd_q, rows[k][32:1]);
         chk(er_q, rows[k][0]);
      end
      // missing enable keeps speed mode
      apb(1'b1, 12'h000, 32'hC);
      cmd_in <= 1'b1;
      repeat (8) @(posedge clk);
      chk(speed_ref_q, 16'sd50);
      chk({pos_loop_active_q, speed_kp_q}, 17'h00011);
      cmd_in <= 1'b0;
      apb(1'b1, 12'h000, 32'hD);
      cmd_in <= 1'b1;
      for (i = 0; i < 40 && speed_ref_q !== 16'sd1000; i++) @(posedge clk);
      tmo(i, 40);
      chk(speed_ref_q, 16'sd1000);
      st(3'd1);
      repeat (SC) @(posedge clk);
      st(3'd2);
      aps_enc_model_i.zero();
      st(3'd3);
      chk(irq_q, 1'b0);
      repeat (5) aps_enc_model_i.step(1'b1);
      @(posedge clk);
      chk(speed_ref_q, 16'sd5);
      st(3'd3);
      chk(logic_outputs_q, 6'h3E);
      repeat (5) aps_enc_model_i.step(1'b1);
      st(3'd5);
      chk(speed_ref_q, 16'sd0);
      chk({speed_kp_q, speed_ki_q, speed_kd_q}, 48'h002100220023);
      chk({pos_loop_active_q, logic_outputs_q, irq_q}, 8'hFF);
      apb(1'b1, 12'h040, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq_q, 1'b0);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd_q, 32'h2);
      // drop the command in the hold state
      cmd_in <= 1'b0;
      repeat (6) @(posedge clk);
      chk({pos_loop_active_q, speed_kp_q}, 17'h00011);
      chk(speed_ref_q, 16'sd50);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd_q[2], 1'b1);
      // reverse run with suppression
      apb(1'b1, 12'h000, 32'hF);
      speed_demand <= -16'sd100;
      repeat (4) @(posedge clk);
      cmd_in <= 1'b1;
      for (i = 0; i < 40 && speed_ref_q !== -16'sd1000; i++) @(posedge clk);
      tmo(i, 40);
      chk(speed_ref_q, -16'sd1000);
      repeat (SC + 4) @(posedge clk);
      aps_enc_model_i.zero();
      repeat (4) aps_enc_model_i.step(1'b0);
      for (i = 0; i < 20 && suppress_q !== 1'b1; i++) @(posedge clk);
      tmo(i, 20);
      repeat (3) @(posedge clk);
      chk({display_h_q, display_3_q}, 2'b10);
      repeat (BC) @(posedge clk);
      chk({display_h_q, display_3_q}, 2'b01);
      st(3'd4);
      conclude();
   end
endmodule

// ===== aps_enc_model.sv
// quadrature encoder with zero pulse, moved by bench task calls
// assumes the caller sits just after a rising clk edge
`timescale 1ns/1ps
module aps_enc_model (
   input  wire logic clk,
   output logic      enc_a,
   output logic      enc_b,
   output logic      enc_zero
);
   logic [1:0] ph_q = 2'h0;
   initial enc_zero = 1'b0;
   // a leads b when stepping forward
   assign enc_a = ph_q[1] ^ ph_q[0];
   assign enc_b = ph_q[1];
   task automatic step(input logic fwd);
      ph_q <= fwd ? ph_q + 2'h1 : ph_q - 2'h1;
      repeat (4) @(posedge clk);
   endtask
   task automatic zero();
      enc_zero <= 1'b1;
      repeat (4) @(posedge clk);
      enc_zero <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ===== aps_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz clock and a 32-bit APB register bus
`ifndef APS_MAP_SVH
`define APS_MAP_SVH

`define APS_OFS_CTRL       12'h000
`define APS_OFS_MULT       12'h004
`define APS_OFS_APPROACH   12'h008
`define APS_OFS_FWD_REF    12'h00C
`define APS_OFS_REV_REF    12'h010
`define APS_OFS_TOL        12'h014
`define APS_OFS_POS_GAIN   12'h018
`define APS_OFS_HOLD_KP    12'h01C
`define APS_OFS_HOLD_KI    12'h020
`define APS_OFS_HOLD_KD    12'h024
`define APS_OFS_NORM_KP    12'h028
`define APS_OFS_NORM_KI    12'h02C
`define APS_OFS_NORM_KD    12'h030
`define APS_OFS_FULL_SCALE 12'h034
`define APS_OFS_OUT_SEL    12'h038
`define APS_OFS_STATUS     12'h03C
`define APS_OFS_INT_STAT   12'h040
`define APS_OFS_INT_MASK   12'h044
`define APS_OFS_POSITION   12'h048

`define APS_CTRL_ENABLE    0
`define APS_CTRL_SUPPRESS  1
`define APS_CTRL_FB_ENC    2
`define APS_CTRL_RAMP_BYP  3
`define APS_OUT_SW_LSB     8

`define APS_INT_DONE       0
`define APS_INT_ZERO       1
`define APS_INT_ABORT      2

`define APS_RST_CTRL       4'h0
`define APS_RST_WORD       16'h0000
`define APS_RST_FULL_SCALE 16'h2710
`define APS_RST_POS_GAIN   16'h0100

`define APS_CLK_KHZ        125000
`define APS_SETTLE_MS      200
`define APS_BLINK_MS       500

`endif

// ===== aps_pkg.sv
// types shared by the positioning sequencer
// constants live in aps_map.svh
package aps_pkg;
   typedef enum logic [2:0] {
      ST_SPEED,
      ST_APPROACH,
      ST_ZERO_WAIT,
      ST_POSITION,
      ST_DONE_SUPPR,
      ST_DONE_HOLD
   } aps_state_type;

   typedef logic signed [15:0] aps_speed_type;
endpackage

// ===== aps_pos_law.sv
// proportional position law with magnitude limit
// assumes error in encoder pulses, gain in 1/256 steps
`timescale 1ns/1ps
module aps_pos_law
   import aps_pkg::*;
(
   input  wire logic signed [31:0] err,
   input  wire logic        [15:0] gain,
   input  wire logic        [15:0] limit,
   output aps_speed_type           cmd,
   output logic             [31:0] abs_err
);
   logic signed [48:0] prod;
   logic signed [48:0] scaled;
   logic signed [48:0] lim_s;

   always_comb begin
      abs_err = err[31] ? 32'(-err) : 32'(err);
      prod    = err * $signed({1'b0, gain});
      scaled  = prod >>> 8;
      lim_s   = $signed({33'h0, limit});
      if (scaled > lim_s) begin
         cmd = aps_speed_type'(limit);
      end else if (scaled < -lim_s) begin
         cmd = aps_speed_type'(-$signed({1'b0, limit}));
      end else begin
         cmd = scaled[15:0];
      end
   end
endmodule

// ===== aps_seq.sv
// angular positioning sequencer with APB register file
// assumes quadrature encoder pins, speed feedback on clk, one clock
`timescale 1ns/1ps
`include "aps_map.svh"

// Function
// - command off: plain speed regulation only
// - command on: approach speed, sign from rotation
// - zero search after speed held 200ms
// - forward or reverse reference by direction
// - references in pulses, speed in percent
// - nonzero multiplier scales the reference
// - proportional gain applied to position error
// - error inside tolerance: stop, declare complete
// - suppress option: suppress and blink H/3
// - no suppress: hold with alternate gains
// - logic outputs may show error-zero
module aps_seq
   import aps_pkg::*;
#(
   parameter int unsigned SETTLE_CYC =
      `APS_SETTLE_MS * (`APS_CLK_KHZ),
   parameter int unsigned BLINK_CYC  =
      `APS_BLINK_MS * (`APS_CLK_KHZ),
   parameter logic [15:0] REACH_BAND = 16'h0010
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata_q,
   output logic             pready_q,
   output logic             pslverr_q,
   input  wire logic        position_command_input,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        enc_zero,
   input  aps_speed_type    speed_fb,
   input  aps_speed_type    speed_demand,
   output aps_speed_type    speed_ref_q,
   output logic             pos_loop_active_q,
   output logic             suppress_q,
   output logic             display_h_q,
   output logic             display_3_q,
   output logic      [15:0] speed_kp_q,
   output logic      [15:0] speed_ki_q,
   output logic      [15:0] speed_kd_q,
   output logic      [5:0]  logic_outputs_q,
   output logic             irq_q
);
   localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYC - 1);
   localparam logic [31:0] BLINK_LAST  = 32'(BLINK_CYC - 1);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // configuration registers
   logic [3:0]  ctrl_q;
   logic [15:0] mult_q;
   logic [6:0]  approach_q;
   logic [15:0] fwd_ref_q;
   logic [15:0] rev_ref_q;
   logic [31:0] tol_q;
   logic [15:0] pos_gain_q;
   logic [15:0] hold_kp_q;
   logic [15:0] hold_ki_q;
   logic [15:0] hold_kd_q;
   logic [15:0] norm_kp_q;
   logic [15:0] norm_ki_q;
   logic [15:0] norm_kd_q;
   logic [15:0] full_scale_q;
   logic [13:0] out_sel_q;
   logic [2:0]  int_stat_q;
   logic [2:0]  int_mask_q;

   // pin synchronisers
   logic [3:0]  sync1_q;
   logic [3:0]  sync2_q;
   logic [3:0]  prev_q;

   aps_state_type      state_q;
   logic               dir_q;
   logic [31:0]        settle_q;
   logic signed [31:0] pos_q;
   logic [31:0]        blink_q;
   logic               blink_ph_q;

   logic               wr_en;
   logic               rd_en;
   logic               cfg_ok;
   logic               cmd_act;
   logic               z_rise;
   logic               reached;
   logic [22:0]        tgt_prod;
   logic [15:0]        target;
   aps_speed_type      target_s;
   aps_speed_type      approach_ref;
   logic signed [16:0] spd_diff;
   logic [16:0]        spd_dev;
   logic [31:0]        ref_base;
   logic [31:0]        ref_eff;
   logic signed [31:0] travel;
   logic signed [31:0] err;
   aps_speed_type      law_cmd;
   logic [31:0]        abs_err;
   logic               in_tol;
   logic               err_zero;
   logic [2:0]         events;
   logic [2:0]         int_clr;

   assign wr_en = psel && penable && pready_q && pwrite;
   assign rd_en = psel && penable && !pready_q;

   // APB answer: one wait state, unmapped raises pslverr
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= 1'b0;
         if (rd_en) begin
            prdata_q <= 32'h0000_0000;
            case (paddr)
               `APS_OFS_CTRL:       prdata_q <= {28'h0, ctrl_q};
               `APS_OFS_MULT:       prdata_q <= {16'h0, mult_q};
               `APS_OFS_APPROACH:   prdata_q <= {25'h0, approach_q};
               `APS_OFS_FWD_REF:    prdata_q <= {16'h0, fwd_ref_q};
               `APS_OFS_REV_REF:    prdata_q <= {16'h0, rev_ref_q};
               `APS_OFS_TOL:        prdata_q <= tol_q;
               `APS_OFS_POS_GAIN:   prdata_q <= {16'h0, pos_gain_q};
               `APS_OFS_HOLD_KP:    prdata_q <= {16'h0, hold_kp_q};
               `APS_OFS_HOLD_KI:    prdata_q <= {16'h0, hold_ki_q};
               `APS_OFS_HOLD_KD:    prdata_q <= {16'h0, hold_kd_q};
               `APS_OFS_NORM_KP:    prdata_q <= {16'h0, norm_kp_q};
               `APS_OFS_NORM_KI:    prdata_q <= {16'h0, norm_ki_q};
               `APS_OFS_NORM_KD:    prdata_q <= {16'h0, norm_kd_q};
               `APS_OFS_FULL_SCALE: prdata_q <= {16'h0, full_scale_q};
               `APS_OFS_OUT_SEL:    prdata_q <= {18'h0, out_sel_q};
               `APS_OFS_STATUS:
                  prdata_q <= {24'h0, err_zero, dir_q, suppress_q,
                               2'h0, state_q};
               `APS_OFS_INT_STAT:   prdata_q <= {29'h0, int_stat_q};
               `APS_OFS_INT_MASK:   prdata_q <= {29'h0, int_mask_q};
               `APS_OFS_POSITION:   prdata_q <= pos_q;
               default:             pslverr_q <= 1'b1;
            endcase
         end else if (psel && penable && !pready_q) begin
            pslverr_q <= 1'b0;
         end
         if (psel && penable && !pready_q && pwrite) begin
            case (paddr)
               `APS_OFS_STATUS, `APS_OFS_POSITION: pslverr_q <= 1'b1;
               default: ;
            endcase
         end
      end
   end

   // register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q       <= `APS_RST_CTRL;
         mult_q       <= `APS_RST_WORD;
         approach_q   <= 7'h00;
         fwd_ref_q    <= `APS_RST_WORD;
         rev_ref_q    <= `APS_RST_WORD;
         tol_q        <= 32'h0000_0000;
         pos_gain_q   <= `APS_RST_POS_GAIN;
         hold_kp_q    <= `APS_RST_WORD;
         hold_ki_q    <= `APS_RST_WORD;
         hold_kd_q    <= `APS_RST_WORD;
         norm_kp_q    <= `APS_RST_WORD;
         norm_ki_q    <= `APS_RST_WORD;
         norm_kd_q    <= `APS_RST_WORD;
         full_scale_q <= `APS_RST_FULL_SCALE;
         out_sel_q    <= 14'h0000;
         int_mask_q   <= 3'h0;
      end else if (wr_en) begin
         case (paddr)
            `APS_OFS_CTRL:       ctrl_q       <= pwdata[3:0];
            `APS_OFS_MULT:       mult_q       <= pwdata[15:0];
            `APS_OFS_APPROACH:   approach_q   <= pwdata[6:0];
            `APS_OFS_FWD_REF:    fwd_ref_q    <= pwdata[15:0];
            `APS_OFS_REV_REF:    rev_ref_q    <= pwdata[15:0];
            `APS_OFS_TOL:        tol_q        <= pwdata;
            `APS_OFS_POS_GAIN:   pos_gain_q   <= pwdata[15:0];
            `APS_OFS_HOLD_KP:    hold_kp_q    <= pwdata[15:0];
            `APS_OFS_HOLD_KI:    hold_ki_q    <= pwdata[15:0];
            `APS_OFS_HOLD_KD:    hold_kd_q    <= pwdata[15:0];
            `APS_OFS_NORM_KP:    norm_kp_q    <= pwdata[15:0];
            `APS_OFS_NORM_KI:    norm_ki_q    <= pwdata[15:0];
            `APS_OFS_NORM_KD:    norm_kd_q    <= pwdata[15:0];
            `APS_OFS_FULL_SCALE: full_scale_q <= pwdata[15:0];
            `APS_OFS_OUT_SEL:    out_sel_q    <= pwdata[13:0];
            `APS_OFS_INT_MASK:   int_mask_q   <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // two-flop pin synchronisers, third stage for edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         prev_q  <= 4'h0;
      end else begin
         sync1_q <= {position_command_input, enc_zero, enc_b, enc_a};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // relied on: function runs only when configured
   assign cfg_ok  = ctrl_q[`APS_CTRL_ENABLE] && ctrl_q[`APS_CTRL_FB_ENC]
                    && ctrl_q[`APS_CTRL_RAMP_BYP];
   assign cmd_act = sync2_q[3] && cfg_ok;
   assign z_rise  = sync2_q[2] && !prev_q[2];

   // approach magnitude as percent of full scale
   assign tgt_prod     = {16'h0000, approach_q} * {7'h00, full_scale_q};
   assign target       = 16'(tgt_prod / 23'd100);
   assign target_s     = aps_speed_type'(target);
   assign approach_ref = dir_q ? aps_speed_type'(-target_s) : target_s;
   assign spd_diff     = 17'(speed_fb - approach_ref);
   assign spd_dev      = spd_diff[16] ? 17'(-spd_diff) : 17'(spd_diff);
   assign reached      = spd_dev <= {1'b0, REACH_BAND};

   assign ref_base = dir_q ? {16'h0, rev_ref_q} : {16'h0, fwd_ref_q};
   assign ref_eff  = (mult_q != 16'h0000) ?
                     (ref_base * {16'h0000, mult_q}) : ref_base;
   assign travel   = dir_q ? 32'(-pos_q) : pos_q;
   assign err      = $signed(ref_eff) - travel;
   assign in_tol   = abs_err < tol_q;
   assign err_zero = (state_q == ST_DONE_SUPPR ||
                      state_q == ST_DONE_HOLD) && in_tol;

   aps_pos_law u_law (
      .err     (err),
      .gain    (pos_gain_q),
      .limit   (target),
      .cmd     (law_cmd),
      .abs_err (abs_err)
   );

   // quadrature count, cleared on zero pulse acquisition
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= 32'sh0000_0000;
      end else if (state_q == ST_ZERO_WAIT && z_rise) begin
         pos_q <= 32'sh0000_0000;
      end else if (sync2_q[1:0] != prev_q[1:0]) begin
         pos_q <= (sync2_q[0] ^ prev_q[1]) ? pos_q + 32'sd1
                                           : pos_q - 32'sd1;
      end
   end

   // sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_SPEED;
         dir_q    <= 1'b0;
         settle_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            ST_SPEED: begin
               settle_q <= 32'h0000_0000;
               if (cmd_act) begin
                  dir_q   <= speed_fb < 0;
                  state_q <= ST_APPROACH;
               end
            end
            ST_APPROACH: begin
               if (!reached) begin
                  settle_q <= 32'h0000_0000;
               end else if (settle_q == SETTLE_LAST) begin
                  state_q <= ST_ZERO_WAIT;
               end else begin
                  settle_q <= settle_q + 32'h1;
               end
            end
            ST_ZERO_WAIT: begin
               if (z_rise) begin
                  state_q <= ST_POSITION;
               end
            end
            ST_POSITION: begin
               if (in_tol) begin
                  state_q <= ctrl_q[`APS_CTRL_SUPPRESS] ?
                             ST_DONE_SUPPR : ST_DONE_HOLD;
               end
            end
            ST_DONE_SUPPR, ST_DONE_HOLD: ;
            default: state_q <= ST_SPEED;
         endcase
         if (!cmd_act && state_q != ST_SPEED) begin
            state_q <= ST_SPEED;
         end
      end
   end

   // speed reference and gain selection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_ref_q       <= 16'sh0000;
         pos_loop_active_q <= 1'b0;
         suppress_q        <= 1'b0;
         speed_kp_q        <= `APS_RST_WORD;
         speed_ki_q        <= `APS_RST_WORD;
         speed_kd_q        <= `APS_RST_WORD;
      end else begin
         pos_loop_active_q <= state_q == ST_POSITION ||
                              state_q == ST_DONE_HOLD;
         suppress_q        <= state_q == ST_DONE_SUPPR;
         speed_kp_q        <= norm_kp_q;
         speed_ki_q        <= norm_ki_q;
         speed_kd_q        <= norm_kd_q;
         case (state_q)
            ST_SPEED:      speed_ref_q <= speed_demand;
            ST_APPROACH:   speed_ref_q <= approach_ref;
            ST_ZERO_WAIT:  speed_ref_q <= approach_ref;
            ST_POSITION:
               speed_ref_q <= dir_q ? aps_speed_type'(-law_cmd) : law_cmd;
            ST_DONE_SUPPR: speed_ref_q <= 16'sh0000;
            ST_DONE_HOLD: begin
               speed_ref_q <= dir_q ? aps_speed_type'(-law_cmd) : law_cmd;
               speed_kp_q  <= hold_kp_q;
               speed_ki_q  <= hold_ki_q;
               speed_kd_q  <= hold_kd_q;
            end
            default:       speed_ref_q <= 16'sh0000;
         endcase
      end
   end

   // alternating H and 3 while suppressed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blink_q     <= 32'h0000_0000;
         blink_ph_q  <= 1'b0;
         display_h_q <= 1'b0;
         display_3_q <= 1'b0;
      end else if (state_q != ST_DONE_SUPPR) begin
         blink_q     <= 32'h0000_0000;
         blink_ph_q  <= 1'b0;
         display_h_q <= 1'b0;
         display_3_q <= 1'b0;
      end else begin
         display_h_q <= !blink_ph_q;
         display_3_q <= blink_ph_q;
         if (blink_q == BLINK_LAST) begin
            blink_q    <= 32'h0000_0000;
            blink_ph_q <= !blink_ph_q;
         end else begin
            blink_q <= blink_q + 32'h1;
         end
      end
   end

   for (genvar i = 0; i < 6; i++) begin : g_out
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            logic_outputs_q[i] <= 1'b0;
         end else begin
            logic_outputs_q[i] <= out_sel_q[i] ? err_zero
                                  : out_sel_q[`APS_OUT_SW_LSB + i];
         end
      end
   end

   // sticky events, set wins over write-one-clear
   assign events[`APS_INT_DONE]  = state_q == ST_POSITION && in_tol &&
                                   cmd_act;
   assign events[`APS_INT_ZERO]  = state_q == ST_ZERO_WAIT && z_rise &&
                                   cmd_act;
   assign events[`APS_INT_ABORT] = state_q != ST_SPEED && !cmd_act;
   assign int_clr = (wr_en && paddr == `APS_OFS_INT_STAT) ?
                    pwdata[2:0] : 3'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_stat_q <= 3'h0;
         irq_q      <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~int_clr) | events;
         irq_q      <= |(int_stat_q & int_mask_q);
      end
   end

   a_idle_speed_mode: assert property (
      state_q == ST_SPEED |=> speed_ref_q == $past(speed_demand)
                              && !pos_loop_active_q)
      else $error("speed mode does not pass the demand");
   a_approach_sign: assert property (
      (state_q == ST_APPROACH && $past(state_q) == ST_APPROACH)
      |=> speed_ref_q == (dir_q ? -$past(target_s) : $past(target_s)))
      else $error("approach speed wrong magnitude or sign");
   a_settle_hold: assert property (
      (state_q == ST_APPROACH && !reached) |=> state_q != ST_ZERO_WAIT)
      else $error("zero search began before speed settled");
   a_ref_direction: assert property (
      (state_q == ST_POSITION && mult_q == 16'h0000)
      |-> err == $signed({16'h0, dir_q ? rev_ref_q : fwd_ref_q})
                 - (dir_q ? -pos_q : pos_q))
      else $error("position reference not chosen by direction");
   a_ref_multiply: assert property (
      (state_q == ST_POSITION && mult_q != 16'h0000 && !dir_q)
      |-> err == $signed(32'(fwd_ref_q * mult_q)) - pos_q)
      else $error("reference multiplier not applied");
   a_complete_tol: assert property (
      (state_q == ST_POSITION && abs_err < tol_q && cmd_act)
      |=> state_q inside {ST_DONE_SUPPR, ST_DONE_HOLD})
      else $error("positioning did not complete inside tolerance");
   a_suppress_stop: assert property (
      state_q == ST_DONE_SUPPR |=> suppress_q && speed_ref_q == 0)
      else $error("suppression not entered after completion");
   a_hold_gains: assert property (
      state_q == ST_DONE_HOLD |=> speed_kp_q == $past(hold_kp_q)
         && speed_ki_q == $past(hold_ki_q)
         && speed_kd_q == $past(hold_kd_q) && !suppress_q)
      else $error("alternate gains not applied while holding");
   a_err_zero_out: assert property (
      out_sel_q[0] |=> logic_outputs_q[0] == $past(err_zero))
      else $error("error-zero output mismatch");
   a_abort_cmd: assert property (
      (!cmd_act && state_q != ST_SPEED) |=> state_q == ST_SPEED)
      else $error("command loss did not abort");
endmodule
